// ==== hdl/ues_defines.vh ====
`ifndef UES_DEFINES_VH
`define UES_DEFINES_VH
// Register byte offsets.
`define UES_OFF_MASK      12'h108
`define UES_OFF_SEV       12'h10C
// Event bit positions shared by mask and severity.
`define UES_BIT_OBSOLETE  0
`define UES_BIT_LINKPROT  4
`define UES_BIT_SURPDOWN  5
`define UES_BIT_POISONED  12
`define UES_BIT_FLOWCTRL  13
`define UES_BIT_CMPLTO    14
`define UES_BIT_CMPLABT   15
`define UES_BIT_UNEXPCPL  16
`define UES_BIT_RCVOVFL   17
`define UES_BIT_MALFORM   18
`define UES_BIT_E2ECRC    19
`define UES_BIT_UNSUPREQ  20
// Writable bits of each register.
`define UES_SEV_WMASK     32'h001F3031
`define UES_MASK_WMASK    32'h001F3031
// Reset values.
`define UES_SEV_RESET     32'h00062030
`define UES_MASK_RESET    32'h00000000
`endif

// ==== hdl/ues_sticky_reg.v ====
`timescale 1ns/100ps
// One sticky register: only power-on reset restores its default.
module ues_sticky_reg #(
  parameter [31:0] RESET_VAL = 32'h00000000,
  parameter [31:0] WMASK     = 32'hFFFFFFFF
) (
  input  wire        clk,
  input  wire        rst,
  input  wire        wr_en,
  input  wire [31:0] wr_data,
  output wire [31:0] value
);
  reg [31:0] value_q; // Stored bits.

  // Writes touch only the writable positions; others stay constant.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      value_q <= RESET_VAL;
    end else if (wr_en) begin
      value_q <= (wr_data & WMASK) | (value_q & ~WMASK);
    end
  end

  // Fixed positions are forced to their reset value (zero).
  assign value = (value_q & WMASK) | (RESET_VAL & ~WMASK);
endmodule

// ==== hdl/ues_severity_bank.v ====
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`include "ues_defines.vh"
module ues_severity_bank (
  clk,
  rst,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  event_in,
  fatal_report,
  nonfatal_report,
  log_event
);
  input  wire        clk;             // 10 MHz clock.
  input  wire        rst;             // Power-on reset, async, high.
  input  wire        psel;            // APB select.
  input  wire        penable;         // APB access phase.
  input  wire        pwrite;          // APB direction.
  input  wire [11:0] paddr;           // APB byte address.
  input  wire [31:0] pwdata;          // APB write data.
  output reg  [31:0] prdata;          // APB read data, registered.
  output wire        pready;          // Always ready.
  output reg         pslverr;         // Error on unmapped address.
  input  wire [31:0] event_in;        // One-cycle event pulses.
  output reg  [31:0] fatal_report;    // Events reported fatal.
  output reg  [31:0] nonfatal_report; // Events reported non-fatal.
  output reg  [31:0] log_event;       // Events passed to status log.

  // Register contents as software sees them.
  wire [31:0] sev_val;   // Severity register contents.
  wire [31:0] mask_val;  // Mask register contents.
  wire [31:0] sev_view;  // Severity word rebuilt from named controls.

  // Register bus phase and address decode.
  wire        setup;     // Setup phase of a transfer.
  wire        hit_sev;   // Address selects severity register.
  wire        hit_mask;  // Address selects mask register.
  wire        wr_sev;    // Write strobe for the severity register.
  wire        wr_mask;   // Write strobe for the mask register.

  // Named severity controls, one per event position.
  wire        obsolete_bit;                 // Stored, drives only the read-back word.
  wire        link_protocol_error_sev;      // Data link protocol errors.
  wire        surprise_down_sev;            // Surprise-down errors.
  wire        poisoned_pkt_sev;             // Poisoned packets.
  wire        flow_ctrl_protocol_error_sev; // Flow control errors.
  wire        completion_timeout_sev;       // Fixed zero position.
  wire        completer_abort_sev;          // Fixed zero position.
  wire        unexpected_completion_sev;    // Unexpected completions.
  wire        receiver_overflow_sev;        // Receiver overflow events.
  wire        malformed_pkt_sev;            // Malformed packets.
  wire        e2e_crc_sev;                  // End-to-end CRC errors.
  wire        unsupported_req_sev;          // Unsupported requests.

  // Mask bits of the events that can be reported.
  wire        link_protocol_error_msk;      // Silences link protocol.
  wire        surprise_down_msk;            // Silences surprise-down.
  wire        poisoned_pkt_msk;             // Silences poisoned packets.
  wire        flow_ctrl_protocol_error_msk; // Silences flow control.
  wire        unexpected_completion_msk;    // Silences unexpected cpl.
  wire        receiver_overflow_msk;        // Silences receiver overflow.
  wire        malformed_pkt_msk;            // Silences malformed packets.
  wire        e2e_crc_msk;                  // Silences end-to-end CRC.
  wire        unsupported_req_msk;          // Silences unsupported req.

  // Events that fired in this cycle with their mask bit clear.
  wire        link_protocol_error_hit;      // Link protocol passes.
  wire        surprise_down_hit;            // Surprise-down passes.
  wire        poisoned_pkt_hit;             // Poisoned packet passes.
  wire        flow_ctrl_protocol_error_hit; // Flow control passes.
  wire        unexpected_completion_hit;    // Unexpected cpl passes.
  wire        receiver_overflow_hit;        // Receiver overflow passes.
  wire        malformed_pkt_hit;            // Malformed packet passes.
  wire        e2e_crc_hit;                  // End-to-end CRC passes.
  wire        unsupported_req_hit;          // Unsupported req passes.

  // Combined vectors feeding the flip-flops.
  reg  [31:0] live;        // Unmasked, reportable events.
  reg  [31:0] fatal_d;     // Next fatal report vector.
  reg  [31:0] nonfatal_d;  // Next non-fatal report vector.
  reg  [31:0] prdata_d;    // Next read data.
  reg         pslverr_d;   // Next slave error flag.

  // Zero-wait slave: every access completes in its first access cycle.
  assign pready   = 1'b1;
  assign setup    = psel & ~penable;
  assign hit_sev  = (paddr == `UES_OFF_SEV);
  assign hit_mask = (paddr == `UES_OFF_MASK);

  // A write lands only at the access edge of a matching transfer.
  assign wr_sev   = psel & penable & pwrite & hit_sev;
  assign wr_mask  = psel & penable & pwrite & hit_mask;

  // Severity register: bits 0,4,5,12,13,16-20 writable and sticky.
  ues_sticky_reg #(
    .RESET_VAL (`UES_SEV_RESET),
    .WMASK     (`UES_SEV_WMASK)
  ) u_sev (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_sev),
    .wr_data (pwdata),
    .value   (sev_val)
  );

  // Mask register: same writable positions, cleared at power-on.
  ues_sticky_reg #(
    .RESET_VAL (`UES_MASK_RESET),
    .WMASK     (`UES_MASK_WMASK)
  ) u_mask (
    .clk     (clk),
    .rst     (rst),
    .wr_en   (wr_mask),
    .wr_data (pwdata),
    .value   (mask_val)
  );

  // Severity controls picked out of the register by position.
  assign obsolete_bit                 = sev_val[`UES_BIT_OBSOLETE];
  assign link_protocol_error_sev      = sev_val[`UES_BIT_LINKPROT];
  assign surprise_down_sev            = sev_val[`UES_BIT_SURPDOWN];
  assign poisoned_pkt_sev             = sev_val[`UES_BIT_POISONED];
  assign flow_ctrl_protocol_error_sev = sev_val[`UES_BIT_FLOWCTRL];
  assign completion_timeout_sev       = sev_val[`UES_BIT_CMPLTO];
  assign completer_abort_sev          = sev_val[`UES_BIT_CMPLABT];
  assign unexpected_completion_sev    = sev_val[`UES_BIT_UNEXPCPL];
  assign receiver_overflow_sev        = sev_val[`UES_BIT_RCVOVFL];
  assign malformed_pkt_sev            = sev_val[`UES_BIT_MALFORM];
  assign e2e_crc_sev                  = sev_val[`UES_BIT_E2ECRC];
  assign unsupported_req_sev          = sev_val[`UES_BIT_UNSUPREQ];

  // Mask bits picked out of the mask register by position.
  assign link_protocol_error_msk      = mask_val[`UES_BIT_LINKPROT];
  assign surprise_down_msk            = mask_val[`UES_BIT_SURPDOWN];
  assign poisoned_pkt_msk             = mask_val[`UES_BIT_POISONED];
  assign flow_ctrl_protocol_error_msk = mask_val[`UES_BIT_FLOWCTRL];
  assign unexpected_completion_msk    = mask_val[`UES_BIT_UNEXPCPL];
  assign receiver_overflow_msk        = mask_val[`UES_BIT_RCVOVFL];
  assign malformed_pkt_msk            = mask_val[`UES_BIT_MALFORM];
  assign e2e_crc_msk                  = mask_val[`UES_BIT_E2ECRC];
  assign unsupported_req_msk          = mask_val[`UES_BIT_UNSUPREQ];

  // An event passes when it fires and its mask bit is clear.
  assign link_protocol_error_hit      = event_in[`UES_BIT_LINKPROT]
    & ~link_protocol_error_msk;
  assign surprise_down_hit            = event_in[`UES_BIT_SURPDOWN]
    & ~surprise_down_msk;
  assign poisoned_pkt_hit             = event_in[`UES_BIT_POISONED]
    & ~poisoned_pkt_msk;
  assign flow_ctrl_protocol_error_hit = event_in[`UES_BIT_FLOWCTRL]
    & ~flow_ctrl_protocol_error_msk;
  assign unexpected_completion_hit    = event_in[`UES_BIT_UNEXPCPL]
    & ~unexpected_completion_msk;
  assign receiver_overflow_hit        = event_in[`UES_BIT_RCVOVFL]
    & ~receiver_overflow_msk;
  assign malformed_pkt_hit            = event_in[`UES_BIT_MALFORM]
    & ~malformed_pkt_msk;
  assign e2e_crc_hit                  = event_in[`UES_BIT_E2ECRC]
    & ~e2e_crc_msk;
  assign unsupported_req_hit          = event_in[`UES_BIT_UNSUPREQ]
    & ~unsupported_req_msk;

  // Severity word as read back; fixed and reserved positions are zero.
  assign sev_view = {11'h000,                      // Bits 31:21.
                     unsupported_req_sev,
                     e2e_crc_sev,
                     malformed_pkt_sev,
                     receiver_overflow_sev,
                     unexpected_completion_sev,
                     completer_abort_sev,
                     completion_timeout_sev,
                     flow_ctrl_protocol_error_sev,
                     poisoned_pkt_sev,
                     6'h00,                        // Bits 11:6.
                     surprise_down_sev,
                     link_protocol_error_sev,
                     3'h0,                         // Bits 3:1.
                     obsolete_bit};

  // Passing events, also handed to the status log.
  // Bit 0 and the fixed positions have no event path, so they never pass.
  // A masked event is neither logged nor reported.
  always @* begin
    live                        = 32'h00000000;
    live[`UES_BIT_LINKPROT]     = link_protocol_error_hit;
    live[`UES_BIT_SURPDOWN]     = surprise_down_hit;
    live[`UES_BIT_POISONED]     = poisoned_pkt_hit;
    live[`UES_BIT_FLOWCTRL]     = flow_ctrl_protocol_error_hit;
    live[`UES_BIT_UNEXPCPL]     = unexpected_completion_hit;
    live[`UES_BIT_RCVOVFL]      = receiver_overflow_hit;
    live[`UES_BIT_MALFORM]      = malformed_pkt_hit;
    live[`UES_BIT_E2ECRC]       = e2e_crc_hit;
    live[`UES_BIT_UNSUPREQ]     = unsupported_req_hit;
  end

  // Each passing event goes to exactly one report kind.
  always @* begin
    fatal_d    = 32'h00000000;
    nonfatal_d = 32'h00000000;
    fatal_d[`UES_BIT_LINKPROT]    = link_protocol_error_hit
      & link_protocol_error_sev;
    nonfatal_d[`UES_BIT_LINKPROT] = link_protocol_error_hit
      & ~link_protocol_error_sev;
    fatal_d[`UES_BIT_SURPDOWN]    = surprise_down_hit
      & surprise_down_sev;
    nonfatal_d[`UES_BIT_SURPDOWN] = surprise_down_hit
      & ~surprise_down_sev;
    fatal_d[`UES_BIT_POISONED]    = poisoned_pkt_hit
      & poisoned_pkt_sev;
    nonfatal_d[`UES_BIT_POISONED] = poisoned_pkt_hit
      & ~poisoned_pkt_sev;
    fatal_d[`UES_BIT_FLOWCTRL]    = flow_ctrl_protocol_error_hit
      & flow_ctrl_protocol_error_sev;
    nonfatal_d[`UES_BIT_FLOWCTRL] = flow_ctrl_protocol_error_hit
      & ~flow_ctrl_protocol_error_sev;
    fatal_d[`UES_BIT_UNEXPCPL]    = unexpected_completion_hit
      & unexpected_completion_sev;
    nonfatal_d[`UES_BIT_UNEXPCPL] = unexpected_completion_hit
      & ~unexpected_completion_sev;
    fatal_d[`UES_BIT_RCVOVFL]     = receiver_overflow_hit
      & receiver_overflow_sev;
    nonfatal_d[`UES_BIT_RCVOVFL]  = receiver_overflow_hit
      & ~receiver_overflow_sev;
    fatal_d[`UES_BIT_MALFORM]     = malformed_pkt_hit
      & malformed_pkt_sev;
    nonfatal_d[`UES_BIT_MALFORM]  = malformed_pkt_hit
      & ~malformed_pkt_sev;
    fatal_d[`UES_BIT_E2ECRC]      = e2e_crc_hit
      & e2e_crc_sev;
    nonfatal_d[`UES_BIT_E2ECRC]   = e2e_crc_hit
      & ~e2e_crc_sev;
    fatal_d[`UES_BIT_UNSUPREQ]    = unsupported_req_hit
      & unsupported_req_sev;
    nonfatal_d[`UES_BIT_UNSUPREQ] = unsupported_req_hit
      & ~unsupported_req_sev;
  end

  // Read mux: picks the addressed word and flags unmapped addresses.
  always @* begin
    prdata_d  = 32'h00000000;
    pslverr_d = 1'b0;
    if (hit_sev) begin
      // Severity word with its fixed positions forced to zero.
      prdata_d = sev_view;
    end else if (hit_mask) begin
      // Mask word as stored.
      prdata_d = mask_val;
    end else begin
      // Unmapped addresses read zero and flag an error.
      pslverr_d = 1'b1;
    end
  end

  // Read data is captured in setup, so it is valid in the access phase.
  // Outside a transfer the last answer stands unchanged.
  // A write in the same transfer never changes the captured word.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (setup) begin
      prdata  <= prdata_d;
      pslverr <= pslverr_d;
    end
  end

  // Reports are registered one cycle after the event pulse.
  // Each output stands for exactly one cycle per event pulse.
  // Bit 0 and the fixed positions never reach any output.
  // A severity write applies to events in the cycle after its edge.
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      fatal_report    <= 32'h00000000;
      nonfatal_report <= 32'h00000000;
      log_event       <= 32'h00000000;
    end else begin
      fatal_report    <= fatal_d;
      nonfatal_report <= nonfatal_d;
      log_event       <= live;
    end
  end
endmodule

// ==== tb/ues_chk.sv ====
`timescale 1ns/100ps
// Tracks both registers from the APB writes and checks every report.
module ues_chk (
  input wire        clk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire        pready,
  input wire        pslverr,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire [31:0] event_in,
  input wire [31:0] fatal_report,
  input wire [31:0] nonfatal_report,
  input wire [31:0] log_event
);
  reg  [31:0] sev_q, msk_q;                          // Shadow registers.
  wire        acc = psel & penable;                  // Access phase.
  wire [31:0] hit = event_in & ~msk_q & 32'h001F3030; // Unmasked events.
  wire [31:0] hf  = hit & sev_q;                     // Expected fatal.
  wire [31:0] hn  = hit & ~sev_q;                    // Expected non-fatal.
  // Shadow copies follow each completed write.
  always @(posedge clk or posedge rst)
    if (rst) begin
      sev_q <= 32'h00062030;
      msk_q <= 32'h00000000;
    end else if (acc && pwrite && paddr == 12'h10C)
      sev_q <= pwdata & 32'h001F3031;
    else if (acc && pwrite && paddr == 12'h108)
      msk_q <= pwdata & 32'h001F3031;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  a_fatal_sev: assert property (fatal_report == $past(hf))
    else $error("fatal report wrong");
  a_nonfatal_sev: assert property (nonfatal_report == $past(hn))
    else $error("non-fatal report wrong");
  a_log_unmasked: assert property (log_event == $past(hit))
    else $error("logged events wrong");
  a_one_kind: assert property (
    (fatal_report | nonfatal_report) == log_event)
    else $error("report kinds disagree with log");
  a_kinds_apart: assert property (
    (fatal_report & nonfatal_report) == 0)
    else $error("event reported as both kinds");
  a_read_sev: assert property (
    acc && !pwrite && paddr == 12'h10C |-> prdata == sev_q)
    else $error("severity read wrong");
  a_read_mask: assert property (
    acc && !pwrite && paddr == 12'h108 |-> prdata == msk_q)
    else $error("mask read wrong");
  a_unmapped_err: assert property (
    acc && paddr != 12'h108 && paddr != 12'h10C |-> pslverr)
    else $error("no slave error");
  a_mapped_ok: assert property (
    acc && (paddr == 12'h108 || paddr == 12'h10C) |-> !pslverr)
    else $error("slave error on mapped address");
  a_never_fixed: assert property (
    ((fatal_report | nonfatal_report) & 32'hFFE0CFCF) == 0)
    else $error("fixed bit reported");
endmodule
bind ues_severity_bank ues_chk ues_chk_inst (.*);

// ==== tb/ues_rc_model.sv ====
`timescale 1ns/100ps
// Root complex end: each set report bit is one message received.
module ues_rc_model (
  input  wire        clk,
  input  wire        rst,
  input  wire [31:0] fatal_report,
  input  wire [31:0] nonfatal_report,
  output reg  [7:0]  n_fatal,
  output reg  [7:0]  n_nonfatal
);
  // Counts arriving messages of each severity.
  always @(posedge clk or posedge rst)
    if (rst) begin
      n_fatal    <= 8'h00;
      n_nonfatal <= 8'h00;
    end else begin
      n_fatal    <= n_fatal + 8'($countones(fatal_report));
      n_nonfatal <= n_nonfatal + 8'($countones(nonfatal_report));
    end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
// Drives the severity bank over APB and with one-cycle event pulses.
module testbench;
  reg         clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0, event_in = 32'h0, rd;
  reg  [7:0]  fe = 8'h00, fn = 8'h00;
  wire [31:0] prdata, fatal_report, nonfatal_report, log_event;
  wire        pready, pslverr;
  wire [7:0]  n_fatal, n_nonfatal;
  integer     error_cnt = 0, checks_done = 0;
  always #50 clk = ~clk;
  ues_severity_bank ues_severity_bank_inst (.*);
  ues_rc_model ues_rc_model_inst (.*);
  task chk(input [31:0] g, input [31:0] e);
    begin
      checks_done = checks_done + 1;
      if (g !== e) begin
        $display("wrong value at %0t: %h expected %h", $time, g, e);
        error_cnt = error_cnt + 1;
      end
    end
  endtask
  // One APB transfer; the answer is taken at the pready edge.
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1) @(posedge clk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  // Pulses all events for one cycle and checks the reports.
  task ev(input [31:0] s, input [31:0] m);
    begin
      @(posedge clk) event_in <= 32'hFFFFFFFF;
      @(posedge clk) event_in <= 32'h0;
      @(negedge clk);
      chk(fatal_report, s & ~m & 32'h001F3030);
      chk(nonfatal_report, ~s & ~m & 32'h001F3030);
      chk(log_event, ~m & 32'h001F3030);
      fe = fe + 8'($countones(s & ~m & 32'h001F3030));
      fn = fn + 8'($countones(~s & ~m & 32'h001F3030));
    end
  endtask
  task t_access;
    begin
      apb(0, 12'h10C, 0);
      chk(rd, 32'h00062030);
      apb(1, 12'h10C, 32'hFFFFFFFF);
      apb(0, 12'h10C, 0);
      chk(rd, 32'h001F3031);
      apb(0, 12'h200, 0);
      chk({rd[30:0], er}, 32'h1);
    end
  endtask
  task t_events;
    begin
      ev(32'h001F3031, 0);
      apb(1, 12'h10C, 32'h00191001);
      ev(32'h00191001, 0);
      apb(1, 12'h108, 32'hFFE50011);
      apb(0, 12'h108, 0);
      chk(rd, 32'h00050011);
      ev(32'h00191001, 32'h00050011);
      @(posedge clk);
      @(negedge clk);
      chk(n_fatal, fe);
      chk(n_nonfatal, fn);
    end
  endtask
  task t_reset;
    begin
      @(posedge clk) rst <= 1'b1;
      @(posedge clk) rst <= 1'b0;
      apb(0, 12'h10C, 0);
      chk(rd, 32'h00062030);
      apb(0, 12'h108, 0);
      chk(rd, 32'h00000000);
    end
  endtask
  task conclude;
    begin
      if (error_cnt == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
    end
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_access;
    t_events;
    t_reset;
    conclude;
  end
  initial begin
    #100000;
    error_cnt = error_cnt + 1;
    conclude;
  end
endmodule
